// File: pwm_carrier_consts.vh
// Constants for the 8-bit PWM / carrier compare timer
// Function
// - Run bit starts counter with first count clock masked; output inactive while level zero.
// - Duty writes during operation are latched, copied on match with old duty value.
// - Latched duty needs three count clocks before transfer; earlier match does not take it.
// - Period match clears counter, drives output active, raises match interrupt.
// - Duty match drives output inactive without clearing counter or raising interrupt.
// - Clearing run bit clears counter and drives output inactive without raising match interrupt.
// - Carrier mode exists only on instance 1, output gated by companion events.
// - In carrier mode first compare sets low width, second compare high width.
// - Remote enable and gate select low, high, low or carrier on output pin.
// - Carrier gate is master/slave; master read/write, slave read-only.
// - Companion interrupt synced to count clock; master copied to slave two clocks later.
// - Carrier starts with low-width compare; match raises interrupt, clears, switches compare.
// - High-width match raises interrupt, clears counter, switches back; phases repeat.
// - Carrier appears on output pin only while slave gate bit is high.
// - Carrier period is N+M+2 count clocks, high time M+1 count clocks.
// - Companion counter counts when its own enable is set, independent of run bit.
// - Reset clears carrier control register to 00H.
`ifndef PWM_CARRIER_CONSTS_VH
`define PWM_CARRIER_CONSTS_VH

`define ADDR_W              4
`define OFS_MODE            4'h0
`define OFS_PERIOD_CMP      4'h1
`define OFS_DUTY_CMP        4'h2
`define OFS_CARRIER_CTRL    4'h3
`define OFS_PRESCALE        4'h4
`define OFS_COUNT           4'h5
`define OFS_COMP_CTRL       4'h6
`define OFS_COMP_CMP        4'h7
`define OFS_COMP_PRESCALE   4'h8
`define OFS_COMP_COUNT      4'h9

`define MODE_RUN_BIT        0
`define MODE_CARRIER_BIT    1
`define MODE_LEVEL_BIT      2
`define CCTL_SLAVE_BIT      0
`define CCTL_MASTER_BIT     1
`define CCTL_REMOTE_BIT     2
`define COMP_ENABLE_BIT     0

`define RST_BYTE            8'h00
`define RST_CARRIER_CTRL    3'h0
`define DUTY_MIN_AGE        2'h3
`define GATE_XFER_DELAY     2'h2

`endif

// File: tick_divider.v
// Programmable divider giving a one-cycle count-clock enable
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter WIDTH = 8
) (
    input  wire             ref_clk_i,
    input  wire             reset_i,
    input  wire [WIDTH-1:0] divide_i,
    output reg              tick_o
);
    reg [WIDTH-1:0] count;

    // Tick every divide_i+1 reference cycles
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            count  <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (count >= divide_i) begin
            count  <= {WIDTH{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count  <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: pwm_carrier_timer.v
// 8-bit PWM / carrier generator compare timer with companion event counter
`timescale 1ns/10ps
`default_nettype none
`include "pwm_carrier_consts.vh"
module pwm_carrier_timer #(
    parameter CARRIER_CAPABLE = 1,
    parameter PRESCALE_W      = 8
) (
    input  wire                ref_clk_i,
    input  wire                reset_i,
    input  wire [`ADDR_W-1:0]  reg_addr_i,
    input  wire [7:0]          reg_wdata_i,
    input  wire                reg_write_i,
    input  wire                reg_read_i,
    output reg  [7:0]          reg_rdata_o,
    output reg                 match_irq_o,
    output reg                 companion_irq_o,
    output reg                 timer_out_pin_o
);
    // Software-visible control
    reg                  count_run_bit;
    reg                  carrier_mode;
    reg                  out_active_level;
    reg [7:0]            period_compare;
    reg [7:0]            duty_compare;
    reg [7:0]            duty_latch;
    reg                  duty_pending;
    reg [1:0]            duty_age;
    reg                  remote_out_enable;
    reg                  gate_master_bit;
    reg                  gate_slave_bit;
    reg [PRESCALE_W-1:0] timer_prescale;
    reg                  companion_count_enable;
    reg [7:0]            companion_compare;
    reg [PRESCALE_W-1:0] companion_prescale;

    // Timer state
    reg [7:0]            counter;
    reg                  second_cmp_sel;
    reg                  first_tick_mask;
    reg                  out_active;
    reg                  carrier_level;
    reg                  run_q;

    // Companion counter and gate transfer
    reg [7:0]            companion_counter;
    reg                  companion_event;
    reg                  companion_pending;
    reg                  companion_irq_synced;
    reg                  synced_q;
    reg [1:0]            xfer_count;
    reg                  xfer_armed;

    wire                 count_tick;
    wire                 companion_tick;
    wire                 carrier_en;
    wire                 wr_mode;
    wire                 wr_duty;
    wire                 wr_cctl;
    wire                 low_match;
    wire                 high_match;
    wire                 duty_take;
    reg                  next_pin;
    reg  [7:0]           next_rdata;

    tick_divider #(
        .WIDTH    (PRESCALE_W)
    ) u_timer_div (
        .ref_clk_i(ref_clk_i),
        .reset_i  (reset_i),
        .divide_i (timer_prescale),
        .tick_o   (count_tick)
    );

    tick_divider #(
        .WIDTH    (PRESCALE_W)
    ) u_companion_div (
        .ref_clk_i(ref_clk_i),
        .reset_i  (reset_i),
        .divide_i (companion_prescale),
        .tick_o   (companion_tick)
    );

    // Instances built without carrier support stay in PWM mode
    assign carrier_en = (CARRIER_CAPABLE != 0) && carrier_mode;

    assign wr_mode = reg_write_i && (reg_addr_i == `OFS_MODE);
    assign wr_duty = reg_write_i && (reg_addr_i == `OFS_DUTY_CMP);
    assign wr_cctl = reg_write_i && (reg_addr_i == `OFS_CARRIER_CTRL);

    assign low_match  = !second_cmp_sel && (counter == period_compare);
    assign high_match = second_cmp_sel && (counter == duty_compare);
    // Old-value match only takes a latch that has aged enough
    assign duty_take  = high_match && duty_pending && (duty_age == `DUTY_MIN_AGE);

    // Register writes
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            count_run_bit          <= 1'b0;
            carrier_mode           <= 1'b0;
            out_active_level       <= 1'b0;
            period_compare         <= `RST_BYTE;
            timer_prescale         <= {PRESCALE_W{1'b0}};
            companion_count_enable <= 1'b0;
            companion_compare      <= `RST_BYTE;
            companion_prescale     <= {PRESCALE_W{1'b0}};
            remote_out_enable      <= 1'b0;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `OFS_MODE: begin
                    count_run_bit    <= reg_wdata_i[`MODE_RUN_BIT];
                    carrier_mode     <= reg_wdata_i[`MODE_CARRIER_BIT];
                    out_active_level <= reg_wdata_i[`MODE_LEVEL_BIT];
                end
                `OFS_PERIOD_CMP: begin
                    period_compare <= reg_wdata_i;
                end
                `OFS_CARRIER_CTRL: begin
                    remote_out_enable <= reg_wdata_i[`CCTL_REMOTE_BIT];
                end
                `OFS_PRESCALE: begin
                    timer_prescale <= reg_wdata_i[PRESCALE_W-1:0];
                end
                `OFS_COMP_CTRL: begin
                    companion_count_enable <= reg_wdata_i[`COMP_ENABLE_BIT];
                end
                `OFS_COMP_CMP: begin
                    companion_compare <= reg_wdata_i;
                end
                `OFS_COMP_PRESCALE: begin
                    companion_prescale <= reg_wdata_i[PRESCALE_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Second compare: shadow latch while running, direct load while stopped
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            duty_compare <= `RST_BYTE;
            duty_latch   <= `RST_BYTE;
            duty_pending <= 1'b0;
            duty_age     <= 2'h0;
        end else if (wr_duty) begin
            duty_latch   <= reg_wdata_i;
            duty_age     <= 2'h0;
            if (count_run_bit) begin
                duty_pending <= 1'b1;
            end else begin
                duty_compare <= reg_wdata_i;
                duty_pending <= 1'b0;
            end
        end else if (count_tick && count_run_bit && !first_tick_mask) begin
            if (duty_take) begin
                duty_compare <= duty_latch;
                duty_pending <= 1'b0;
            end
            if (duty_pending && (duty_age != `DUTY_MIN_AGE)) begin
                duty_age <= duty_age + 2'h1;
            end
        end
    end

    // Counter, compare selection and waveform state
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            counter         <= `RST_BYTE;
            second_cmp_sel  <= 1'b0;
            first_tick_mask <= 1'b0;
            out_active      <= 1'b0;
            carrier_level   <= 1'b0;
            match_irq_o     <= 1'b0;
            run_q           <= 1'b0;
        end else begin
            run_q       <= count_run_bit;
            match_irq_o <= 1'b0;
            if (!count_run_bit) begin
                counter         <= `RST_BYTE;
                second_cmp_sel  <= 1'b0;
                out_active      <= 1'b0;
                carrier_level   <= 1'b0;
                first_tick_mask <= 1'b0;
            end else if (!run_q) begin
                // Start: first compare used first, first count clock swallowed
                first_tick_mask <= 1'b1;
                second_cmp_sel  <= 1'b0;
            end else if (count_tick) begin
                if (first_tick_mask) begin
                    first_tick_mask <= 1'b0;
                end else if (low_match) begin
                    counter        <= `RST_BYTE;
                    match_irq_o    <= 1'b1;
                    second_cmp_sel <= 1'b1;
                    if (carrier_en) begin
                        carrier_level <= 1'b1;
                    end else begin
                        out_active <= 1'b1;
                    end
                end else if (high_match && carrier_en) begin
                    // High phase spans M+1 clocks, low phase N+1
                    counter        <= `RST_BYTE;
                    match_irq_o    <= 1'b1;
                    second_cmp_sel <= 1'b0;
                    carrier_level  <= 1'b0;
                end else if (high_match) begin
                    // Duty match leaves the counter running and no interrupt
                    counter        <= counter + 8'h01;
                    second_cmp_sel <= 1'b0;
                    out_active     <= 1'b0;
                end else begin
                    counter <= counter + 8'h01;
                end
            end
        end
    end

    // Companion event counter runs on its own enable only
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            companion_counter <= `RST_BYTE;
            companion_event   <= 1'b0;
            companion_irq_o   <= 1'b0;
        end else begin
            companion_event <= 1'b0;
            companion_irq_o <= 1'b0;
            if (!companion_count_enable) begin
                companion_counter <= `RST_BYTE;
            end else if (companion_tick) begin
                if (companion_counter == companion_compare) begin
                    companion_counter <= `RST_BYTE;
                    companion_event   <= 1'b1;
                    companion_irq_o   <= 1'b1;
                end else begin
                    companion_counter <= companion_counter + 8'h01;
                end
            end
        end
    end

    // Event is held until the next count clock, then shown for one count clock, or two if a count clock falls in the event cycle
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            companion_pending    <= 1'b0;
            companion_irq_synced <= 1'b0;
            synced_q             <= 1'b0;
        end else begin
            if (companion_event) begin
                companion_pending <= 1'b1;
            end else if (count_tick) begin
                companion_pending <= 1'b0;
            end
            if (count_tick) begin
                companion_irq_synced <= companion_pending || companion_event;
                synced_q             <= companion_irq_synced;
            end
        end
    end

    // Master and slave gate bits
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            gate_master_bit <= 1'b0;
            gate_slave_bit  <= 1'b0;
            xfer_count      <= 2'h0;
            xfer_armed      <= 1'b0;
        end else begin
            if (wr_cctl) begin
                gate_master_bit <= reg_wdata_i[`CCTL_MASTER_BIT];
            end
            if (count_tick) begin
                if (companion_irq_synced && !synced_q) begin
                    xfer_armed <= 1'b1;
                    xfer_count <= 2'h1;
                end else if (xfer_armed && (xfer_count == `GATE_XFER_DELAY)) begin
                    // Copy on the second count clock after the rising edge
                    gate_slave_bit <= gate_master_bit;
                    xfer_armed     <= 1'b0;
                    xfer_count     <= 2'h0;
                end else if (xfer_armed) begin
                    xfer_count <= xfer_count + 2'h1;
                end
            end
        end
    end

    // Output pin selection
    always @* begin
        if (carrier_en) begin
            if (!gate_slave_bit) begin
                next_pin = 1'b0;
            end else if (!remote_out_enable) begin
                next_pin = 1'b1;
            end else begin
                next_pin = carrier_level;
            end
        end else begin
            // Level one turns the active state into a low drive
            next_pin = out_active ^ out_active_level;
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            timer_out_pin_o <= 1'b0;
        end else begin
            timer_out_pin_o <= next_pin;
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `OFS_MODE: begin
                next_rdata[`MODE_RUN_BIT]     = count_run_bit;
                next_rdata[`MODE_CARRIER_BIT] = carrier_en;
                next_rdata[`MODE_LEVEL_BIT]   = out_active_level;
            end
            `OFS_PERIOD_CMP: begin
                next_rdata = period_compare;
            end
            `OFS_DUTY_CMP: begin
                next_rdata = duty_latch;
            end
            `OFS_CARRIER_CTRL: begin
                next_rdata[`CCTL_REMOTE_BIT] = remote_out_enable;
                next_rdata[`CCTL_MASTER_BIT] = gate_master_bit;
                next_rdata[`CCTL_SLAVE_BIT]  = gate_slave_bit;
            end
            `OFS_PRESCALE: begin
                next_rdata[PRESCALE_W-1:0] = timer_prescale;
            end
            `OFS_COUNT: begin
                next_rdata = counter;
            end
            `OFS_COMP_CTRL: begin
                next_rdata[`COMP_ENABLE_BIT] = companion_count_enable;
            end
            `OFS_COMP_CMP: begin
                next_rdata = companion_compare;
            end
            `OFS_COMP_PRESCALE: begin
                next_rdata[PRESCALE_W-1:0] = companion_prescale;
            end
            `OFS_COMP_COUNT: begin
                next_rdata = companion_counter;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: pin_load.sv
// Load on the timer output pin that measures each high and low run
`timescale 1ns/10ps
`default_nettype none
module pin_load (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        pin_i,
    output var  logic [15:0] high_len_o,
    output var  logic [15:0] low_len_o
);
    logic [15:0] run;
    logic        last;
    // Widths are in reference cycles, taken when the level flips
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            run <= 16'h0001;
            last <= 1'b0;
            high_len_o <= 16'h0000;
            low_len_o <= 16'h0000;
        end else if (pin_i != last) begin
            if (last) high_len_o <= run;
            else low_len_o <= run;
            run <= 16'h0001;
            last <= pin_i;
        end else begin
            run <= run + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: pwm_carrier_timer_chk.sv
// Assertions on the ports of the PWM / carrier compare timer
`timescale 1ns/10ps
`default_nettype none
`include "pwm_carrier_consts.vh"
module pwm_carrier_timer_chk (
    input wire logic               ref_clk_i,
    input wire logic               reset_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic               reg_write_i,
    input wire logic               reg_read_i,
    input wire logic [7:0]         reg_rdata_o,
    input wire logic               match_irq_o,
    input wire logic               companion_irq_o,
    input wire logic               timer_out_pin_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Shadows of the settings, rebuilt from bus writes
    logic [7:0]  mode;
    logic [7:0]  per;
    logic [7:0]  duty;
    logic [7:0]  pre;
    logic [17:0] gap;
    logic [2:0]  irqs;
    logic [17:0] gap_lo;
    logic [17:0] gap_hi;
    logic [1:0]  ctrl_bits;
    logic        cfg;
    assign ctrl_bits = reg_wdata_i[2:1];
    assign cfg = reg_write_i && reg_addr_i inside {`OFS_MODE, `OFS_PERIOD_CMP, `OFS_DUTY_CMP, `OFS_PRESCALE};
    assign gap_lo = ({10'h000, per} + 18'h00001) * ({10'h000, pre} + 18'h00001);
    assign gap_hi = ({10'h000, duty} + 18'h00001) * ({10'h000, pre} + 18'h00001);
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mode <= 8'h00;
            per <= 8'h00;
            duty <= 8'h00;
            pre <= 8'h00;
            gap <= 18'h00000;
            irqs <= 3'h0;
        end else begin
            if (reg_write_i && reg_addr_i == `OFS_MODE) mode <= reg_wdata_i;
            if (reg_write_i && reg_addr_i == `OFS_PERIOD_CMP) per <= reg_wdata_i;
            if (reg_write_i && reg_addr_i == `OFS_DUTY_CMP) duty <= reg_wdata_i;
            if (reg_write_i && reg_addr_i == `OFS_PRESCALE) pre <= reg_wdata_i;
            gap <= match_irq_o ? 18'h00001 : gap + 18'h00001;
            // A latched width may take two phases to land, so wait out several
            if (cfg) irqs <= 3'h0;
            else if (match_irq_o && irqs != 3'h7) irqs <= irqs + 3'h1;
        end
    end
    sequence s_ctrl_wr;
        reg_write_i && reg_addr_i == `OFS_CARRIER_CTRL;
    endsequence
    sequence s_ctrl_rd;
        reg_read_i && reg_addr_i == `OFS_CARRIER_CTRL;
    endsequence
    sequence s_run_on;
        reg_write_i && reg_addr_i == `OFS_MODE && reg_wdata_i[2:0] == 3'h1 && mode[2:0] == 3'h0;
    endsequence
    sequence s_stop;
        reg_write_i && reg_addr_i == `OFS_MODE && reg_wdata_i[2:0] == 3'h0;
    endsequence
    property p_reset_quiet;
        $fell(reset_i) |-> reg_rdata_o == 8'h00 && !match_irq_o && !companion_irq_o && !timer_out_pin_o;
    endproperty
    property p_rdata_idle;
        !$past(reg_read_i) |-> reg_rdata_o == 8'h00;
    endproperty
    property p_ctrl_readback;
        s_ctrl_wr ##1 s_ctrl_rd |=> reg_rdata_o[7:1] == {5'h00, $past(ctrl_bits, 2)};
    endproperty
    property p_irq_pulse;
        match_irq_o |=> !match_irq_o;
    endproperty
    property p_start_masked;
        s_run_on |=> !timer_out_pin_o [*3];
    endproperty
    property p_stop_quiet;
        s_stop |=> ##2 (!timer_out_pin_o && !match_irq_o) [*4];
    endproperty
    property p_pwm_active;
        match_irq_o && mode[1:0] == 2'h1 && !reg_write_i |-> ##[1:2] timer_out_pin_o == !mode[`MODE_LEVEL_BIT];
    endproperty
    property p_pwm_gap;
        match_irq_o && mode[1:0] == 2'h1 && irqs != 3'h0 |-> gap == gap_lo;
    endproperty
    property p_car_gap;
        match_irq_o && mode[1:0] == 2'h3 && irqs == 3'h7 |-> gap == gap_lo || gap == gap_hi;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read answer");
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("carrier control readback differs");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("match interrupt longer than one cycle");
    a_start_masked: assert property (p_start_masked)
        else $error("output active right after start");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("output or interrupt active after stop");
    a_pwm_active: assert property (p_pwm_active)
        else $error("output not active after period match");
    a_pwm_gap: assert property (p_pwm_gap)
        else $error("period match spacing wrong");
    a_car_gap: assert property (p_car_gap)
        else $error("carrier phase length wrong");
endmodule
`default_nettype wire

// File: pwm_carrier_timer_tb.sv
// Self-checking bench for the PWM / carrier compare timer
`timescale 1ns/10ps
`default_nettype none
`include "pwm_carrier_consts.vh"
module pwm_carrier_timer_tb;
    typedef struct packed {
        logic [7:0]  pre;
        logic [7:0]  per;
        logic [7:0]  dut;
        logic [7:0]  mode;
        logic [15:0] hi;
        logic [15:0] lo;
    } row_t;
    logic        ref_clk_i   = 1'b0;
    logic        reset_i     = 1'b1;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_write_i = 1'b0;
    logic        reg_read_i  = 1'b0;
    wire  [7:0]  reg_rdata_o;
    wire         match_irq_o;
    wire         companion_irq_o;
    wire         timer_out_pin_o;
    wire  [15:0] high_len;
    wire  [15:0] low_len;
    wire  [2:0]  obs = {companion_irq_o, match_irq_o, timer_out_pin_o};
    logic [7:0]  q;
    int          fails = 0;
    int          num_checks = 0;
    // Prescale, period, duty, mode, then expected high and low widths
    row_t rows [0:7] = '{
        {8'h00, 8'h04, 8'h01, 8'h01, 16'h0002, 16'h0003},
        {8'h01, 8'h09, 8'h03, 8'h01, 16'h0008, 16'h000C},
        {8'h00, 8'h03, 8'h00, 8'h01, 16'h0001, 16'h0003},
        {8'h00, 8'hFF, 8'hFE, 8'h01, 16'h00FF, 16'h0001},
        {8'h00, 8'h06, 8'h01, 8'h05, 16'h0005, 16'h0002},
        {8'h00, 8'h03, 8'h03, 8'h03, 16'h0004, 16'h0004},
        {8'h01, 8'h02, 8'h05, 8'h03, 16'h000C, 16'h0006},
        {8'h00, 8'h01, 8'h06, 8'h03, 16'h0007, 16'h0002}};

    pwm_carrier_timer #(.CARRIER_CAPABLE(1), .PRESCALE_W(8)) pwm_carrier_timer_inst (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .match_irq_o(match_irq_o),
        .companion_irq_o(companion_irq_o), .timer_out_pin_o(timer_out_pin_o));
    pin_load pin_load_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .pin_i(timer_out_pin_o),
        .high_len_o(high_len), .low_len_o(low_len));

    always #5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    // Write then read back with no gap between the strobes
    task automatic wrrd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        wr(a, d);
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1;
        r = reg_rdata_o;
    endtask
    task automatic wait_for(input int sel, input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (obs[sel] !== lvl && n < 3000);
        chk({15'h0000, obs[sel]}, {15'h0000, lvl});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge ref_clk_i);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], q);
            chk({8'h00, q}, 16'h0000);
        end
        $display("test reset values done");
        // Companion ticks eight times slower, beyond the sync margin
        wr(`OFS_COMP_PRESCALE, 8'h07);
        wr(`OFS_COMP_CMP, 8'h02);
        wr(`OFS_COMP_CTRL, 8'h01);
        wait_for(2, 1'b1);
        wr(`OFS_PERIOD_CMP, 8'h03);
        wr(`OFS_DUTY_CMP, 8'h03);
        wr(`OFS_MODE, 8'h03);
        for (int g = 0; g < 4; g++) begin
            wrrd(`OFS_CARRIER_CTRL, {5'h00, g[1:0], 1'b0}, q);
            chk({14'h0000, q[2:1]}, {14'h0000, g[1:0]});
            wait_for(2, 1'b1);
            repeat (30) @(posedge ref_clk_i);
            rd(`OFS_CARRIER_CTRL, q);
            chk({15'h0000, q[0]}, {15'h0000, g[0]});
            if (g == 3) chk(high_len, 16'h0004);
            else chk({15'h0000, timer_out_pin_o}, {15'h0000, g == 1});
        end
        $display("test carrier gate done");
        foreach (rows[i]) begin
            wr(`OFS_MODE, 8'h00);
            wr(`OFS_PRESCALE, rows[i].pre);
            wr(`OFS_PERIOD_CMP, rows[i].per);
            wr(`OFS_DUTY_CMP, rows[i].dut);
            wr(`OFS_MODE, rows[i].mode);
            rd(`OFS_MODE, q);
            chk({8'h00, q}, {8'h00, rows[i].mode});
            repeat (3 * (rows[i].per + rows[i].dut + 2) * (rows[i].pre + 1) + 30) @(posedge ref_clk_i);
            chk(high_len, rows[i].hi);
            chk(low_len, rows[i].lo);
            $display("test row %0d done", i);
        end
        wr(`OFS_MODE, 8'h00);
        wr(`OFS_PRESCALE, 8'h00);
        wr(`OFS_PERIOD_CMP, 8'h09);
        wr(`OFS_DUTY_CMP, 8'h02);
        wr(`OFS_MODE, 8'h01);
        // New duty lands one count clock before the old match, too young to transfer
        wait_for(1, 1'b1);
        wr(`OFS_DUTY_CMP, 8'h06);
        rd(`OFS_DUTY_CMP, q);
        chk({8'h00, q}, 16'h0006);
        wait_for(0, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        chk(high_len, 16'h0003);
        for (int p = 0; p < 2; p++) begin
            wait_for(0, 1'b1);
            wait_for(0, 1'b0);
            repeat (2) @(posedge ref_clk_i);
            chk(high_len, p ? 16'h0007 : 16'h0003);
        end
        $display("test duty latch done");
        wait_for(0, 1'b1);
        wr(`OFS_MODE, 8'h00);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk({15'h0000, timer_out_pin_o}, 16'h0000);
        $display("test stop done");
        give_verdict();
    end
endmodule

bind pwm_carrier_timer pwm_carrier_timer_chk pwm_carrier_timer_chk_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .match_irq_o(match_irq_o),
    .companion_irq_o(companion_irq_o), .timer_out_pin_o(timer_out_pin_o));
`default_nettype wire
